/* File: hw/srs_sequencer.sv */
// Staged reset sequencer: gathers reset sources and releases resets in timed stages.
// Assumes clk is the oscillator clock; system clock stages are counted on the same clock.
//
// Notes on behaviour
// - five sources, two async, three sync
// - test-access reset follows power-on reset only
// - power-on reset stretched 64 cycles after release
// - combined reset ORs sources, holds sync logic and every later stage
// - sync reset logic freed three cycles later
// - clock-generator reset freed 32 cycles later
// - clock-generator release aligned to clock edge
// - peripheral reset freed 32 cycles after clock-generator
// - core reset freed 32 cycles after peripheral
// - peripheral and core release on clock edge
// - core runs only after core reset release
// - combined release starts sync logic and stretcher
// - clock-generator release starts peripheral stretcher
// - early stages counted on oscillator clock
// - software write raises a software reset
// - total stretch 96 cycles from combined release to core release
// - no interrupt requests from reset sequencing
`timescale 1ns/100ps
module srs_sequencer
   import srs_pkg::*;
#(
   parameter int POR_STRETCH  = POR_STRETCH_CYCLES,
   parameter int SYNC_RELEASE = SYNC_RELEASE_CYCLES,
   parameter int CLKGEN_HOLD  = CLKGEN_CYCLES,
   parameter int PERIPH_HOLD  = PERIPH_CYCLES,
   parameter int CORE_HOLD    = CORE_CYCLES
) (
   input  wire logic            clk,
   input  wire logic            nrst,
   input  srs_pkg::srs_sources_type sources,
   output srs_pkg::srs_resets_type  resets
);
   import srs_pkg::*;

   // Counters are CNT_WIDTH wide; sync release must fall inside the clock-generator stage
   initial begin
      if (POR_STRETCH < 2 || POR_STRETCH > 127 || CLKGEN_HOLD < 2 || CLKGEN_HOLD > 127 ||
          PERIPH_HOLD < 2 || PERIPH_HOLD > 127 || CORE_HOLD < 2 || CORE_HOLD > 127 ||
          SYNC_RELEASE < 2 || SYNC_RELEASE >= CLKGEN_HOLD) begin
         $error("srs_sequencer: stage length out of range");
      end
   end

   localparam logic [CNT_WIDTH-1:0] POR_LAST    = CNT_WIDTH'(POR_STRETCH - 1);
   localparam logic [CNT_WIDTH-1:0] SYNC_LAST   = CNT_WIDTH'(SYNC_RELEASE - 1);
   localparam logic [CNT_WIDTH-1:0] CLKGEN_LAST = CNT_WIDTH'(CLKGEN_HOLD - 1);
   localparam logic [CNT_WIDTH-1:0] PERIPH_LAST = CNT_WIDTH'(PERIPH_HOLD - 1);
   localparam logic [CNT_WIDTH-1:0] CORE_LAST   = CNT_WIDTH'(CORE_HOLD - 1);
   localparam logic [CNT_WIDTH-1:0] CNT_ONE     = CNT_WIDTH'(1);

   typedef struct packed {
      logic [SYNC_DEPTH-1:0] por_sync;
      logic [SYNC_DEPTH-1:0] ext_sync;
      logic [CNT_WIDTH-1:0]  por_cnt;
      srs_stage_type         stage;
      logic [CNT_WIDTH-1:0]  cnt;
      srs_resets_type        out;
   } srs_state_type;

   srs_state_type st_reg;
   srs_state_type st_next;
   logic          por_s;
   logic          ext_s;
   logic          sync_req;
   logic          comb;

   // Only the second synchroniser flop is looked at
   assign por_s = st_reg.por_sync[SYNC_DEPTH-1];
   assign ext_s = st_reg.ext_sync[SYNC_DEPTH-1];

   // Sync sources are ignored while their own logic is still held in reset
   assign sync_req = (sources.sw_write | sources.watchdog_timeout_reset | sources.clock_loss_reset) &
                     ~st_reg.out.sync_logic_reset;
   assign comb     = st_reg.out.por_stretched | ext_s | sync_req;

   // Next-state logic for synchronisers, stretcher and stage sequencer
   always_comb begin
      st_next = st_reg;
      // Async pins pass two flops before use
      st_next.por_sync = {st_reg.por_sync[SYNC_DEPTH-2:0], sources.por_active};
      st_next.ext_sync = {st_reg.ext_sync[SYNC_DEPTH-2:0], sources.ext_active};

      // Test-access reset follows power-on reset alone
      st_next.out.jtag_reset = por_s;

      // Power-on stretcher runs on the oscillator clock, free of the combined reset
      if (por_s) begin
         st_next.por_cnt           = '0;
         st_next.out.por_stretched = 1'b1;
      end else if (st_reg.out.por_stretched) begin
         st_next.por_cnt = st_reg.por_cnt + CNT_ONE;
         if (st_reg.por_cnt == POR_LAST) begin
            st_next.out.por_stretched = 1'b0;
         end
      end

      st_next.out.combined_reset = comb;
      if (comb) begin
         // Any source back on: everything downstream back in reset
         st_next.stage                     = ST_HOLD;
         st_next.cnt                       = '0;
         st_next.out.sync_logic_reset      = 1'b1;
         st_next.out.clock_generator_reset = 1'b1;
         st_next.out.peripheral_reset      = 1'b1;
         st_next.out.core_reset            = 1'b1;
         st_next.out.core_run              = 1'b0;
      end else begin
         case (st_reg.stage)
            ST_HOLD: begin
               // Combined release starts sync generator and clock-generator stretcher
               st_next.stage = ST_CLKGEN;
               st_next.cnt   = '0;
            end
            ST_CLKGEN: begin
               st_next.cnt = st_reg.cnt + CNT_ONE;
               if (st_reg.cnt == SYNC_LAST) begin
                  st_next.out.sync_logic_reset = 1'b0;
               end
               if (st_reg.cnt == CLKGEN_LAST) begin
                  // Released on a clock edge so all loads see it together
                  st_next.out.clock_generator_reset = 1'b0;
                  st_next.stage                     = ST_PERIPH;
                  st_next.cnt                       = '0;
               end
            end
            ST_PERIPH: begin
               st_next.cnt = st_reg.cnt + CNT_ONE;
               if (st_reg.cnt == PERIPH_LAST) begin
                  st_next.out.peripheral_reset = 1'b0;
                  st_next.stage                = ST_CORE;
                  st_next.cnt                  = '0;
               end
            end
            ST_CORE: begin
               st_next.cnt = st_reg.cnt + CNT_ONE;
               if (st_reg.cnt == CORE_LAST) begin
                  st_next.out.core_reset = 1'b0;
                  st_next.out.core_run   = 1'b1;
                  st_next.stage          = ST_RUN;
                  st_next.cnt            = '0;
               end
            end
            ST_RUN: begin
               st_next.cnt = '0;
            end
            default: begin
               st_next.stage = ST_HOLD;
               st_next.cnt   = '0;
            end
         endcase
      end
   end

   // State register; reset puts every output in its held state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg.por_sync <= SYNC_RESET;
         st_reg.ext_sync <= SYNC_RESET;
         st_reg.por_cnt  <= '0;
         st_reg.stage    <= ST_HOLD;
         st_reg.cnt      <= '0;
         st_reg.out      <= RESETS_AT_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // No interrupt output: sequencing raises no requests
   assign resets = st_reg.out;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_jtag_por_only: assert property (!por_s |=> !resets.jtag_reset)
      else $error("test-access reset held without power-on reset");
   a_por_stretch_min: assert property ($fell(por_s) |-> ##62 (resets.por_stretched || por_s))
      else $error("power-on stretch ended early");
   a_por_stretch_end: assert property ($fell(resets.por_stretched) |-> $past(st_reg.por_cnt) == POR_LAST)
      else $error("power-on stretch ended at wrong count");
   a_comb_or_srcs: assert property ((resets.por_stretched || ext_s) |=> resets.combined_reset)
      else $error("combined reset missed a source");
   a_comb_holds_all: assert property (resets.combined_reset |-> resets.clock_generator_reset &&
                                      resets.peripheral_reset && resets.core_reset)
      else $error("stage released under combined reset");
   a_sync_release: assert property ($fell(resets.sync_logic_reset) |->
                                    !$past(resets.combined_reset, 3) && $past(resets.combined_reset, 4))
      else $error("sync reset logic released at wrong time");
   a_clkgen_delay: assert property ($fell(resets.clock_generator_reset) |->
                                    !$past(resets.combined_reset, 32) && $past(resets.combined_reset, 33))
      else $error("clock-generator reset released at wrong time");
   a_periph_delay: assert property ($fell(resets.peripheral_reset) |->
                                    !$past(resets.clock_generator_reset, 32) &&
                                    $past(resets.clock_generator_reset, 33))
      else $error("peripheral reset released at wrong time");
   a_core_delay: assert property ($fell(resets.core_reset) |->
                                  !$past(resets.peripheral_reset, 32) && $past(resets.peripheral_reset, 33))
      else $error("core reset released at wrong time");
   a_core_run_gate: assert property (resets.core_run |-> !resets.core_reset && !resets.peripheral_reset)
      else $error("core running while in reset");
   a_restart_seq: assert property ((ext_s && !resets.core_reset) |=> resets.core_reset && !resets.core_run)
      else $error("sequence not restarted on new source");

   // Power-on reset alone drives the test-access reset
   a_jtag_follows_por: assert property (por_s |=>
      resets.jtag_reset)
      else $error("test-access reset missed power-on reset");

   // Synchronised power-on reset restarts the stretcher from zero
   a_por_restart_cnt: assert property (por_s |=>
      resets.por_stretched && st_reg.por_cnt == '0)
      else $error("power-on stretcher not restarted");

   // Stretch held until the count reaches its end
   a_por_stretch_hold: assert property ((resets.por_stretched && !por_s && st_reg.por_cnt != POR_LAST) |=>
      resets.por_stretched)
      else $error("power-on stretch dropped early");

   // Once released, the stretch stays off until power-on returns
   a_por_stays_free: assert property ((!resets.por_stretched && !por_s) |=>
      !resets.por_stretched)
      else $error("power-on stretch reasserted without power-on");

   // Stretcher advances one step per oscillator cycle
   a_por_cnt_step: assert property ((resets.por_stretched && !por_s) |=>
      st_reg.por_cnt == $past(st_reg.por_cnt) + CNT_ONE)
      else $error("power-on stretcher skipped a cycle");

   // Accepted synchronous request raises the combined reset
   a_comb_from_sync: assert property (sync_req |=>
      resets.combined_reset)
      else $error("synchronous source did not raise combined reset");

   // No source at all: combined reset must drop
   a_comb_quiet: assert property ((!resets.por_stretched && !ext_s && !sources.sw_write &&
      !sources.watchdog_timeout_reset && !sources.clock_loss_reset) |=> !resets.combined_reset)
      else $error("combined reset held with no source");

   // Synchronous sources refused while their logic is held
   a_sync_refused: assert property ((resets.sync_logic_reset && !resets.por_stretched && !ext_s) |=>
      !resets.combined_reset)
      else $error("synchronous source taken while its logic held");

   // Sync reset logic is held whenever combined reset is
   a_sync_under_comb: assert property (resets.combined_reset |->
      resets.sync_logic_reset)
      else $error("sync reset logic free under combined reset");

   // Sync reset logic stays held three cycles after release
   a_sync_hold_three: assert property ($fell(resets.combined_reset) |->
      resets.sync_logic_reset [*3])
      else $error("sync reset logic released too soon");

   // Clock generator never freed ahead of sync reset logic
   a_clkgen_after_sync: assert property (!resets.clock_generator_reset |->
      !resets.sync_logic_reset)
      else $error("clock generator freed before sync logic");

   // Clock-generator reset still held 31 cycles into the stage
   a_clkgen_held_early: assert property ($fell(resets.combined_reset) |->
      ##31 resets.clock_generator_reset)
      else $error("clock-generator reset released early");

   // Inside its stage, release only at the final count
   a_clkgen_in_stage: assert property ((st_reg.stage == ST_CLKGEN && st_reg.cnt != CLKGEN_LAST) |=>
      resets.clock_generator_reset)
      else $error("clock-generator reset released off its edge");

   // Hold stage lasts one cycle once sources clear
   a_hold_one_cycle: assert property ((st_reg.stage == ST_HOLD && !comb) |=>
      st_reg.stage == ST_CLKGEN && st_reg.cnt == '0)
      else $error("clock-generator stretcher not started");

   // Clock-generator release starts the peripheral stretcher
   a_clkgen_starts_periph: assert property ($fell(resets.clock_generator_reset) |->
      st_reg.stage == ST_PERIPH)
      else $error("peripheral stretcher not started");

   // Peripherals never freed ahead of the clock generator
   a_periph_after_clkgen: assert property (!resets.peripheral_reset |->
      !resets.clock_generator_reset)
      else $error("peripheral freed before clock generator");

   // Peripheral reset still held 31 cycles into its stage
   a_periph_held_early: assert property ($fell(resets.clock_generator_reset) |->
      ##31 resets.peripheral_reset)
      else $error("peripheral reset released early");

   // Inside its stage, peripheral release only at final count
   a_periph_in_stage: assert property ((st_reg.stage == ST_PERIPH && st_reg.cnt != PERIPH_LAST) |=>
      resets.peripheral_reset)
      else $error("peripheral reset released off its edge");

   // Core never freed ahead of the peripherals
   a_core_after_periph: assert property (!resets.core_reset |->
      !resets.peripheral_reset)
      else $error("core freed before peripherals");

   // Core reset still held 31 cycles into its stage
   a_core_held_early: assert property ($fell(resets.peripheral_reset) |->
      ##31 resets.core_reset)
      else $error("core reset released early");

   // Inside its stage, core release only at final count
   a_core_in_stage: assert property ((st_reg.stage == ST_CORE && st_reg.cnt != CORE_LAST) |=>
      resets.core_reset)
      else $error("core reset released off its edge");

   // Run permission is exactly the inverse of core reset
   a_run_matches_core: assert property (1'b1 |->
      resets.core_run == !resets.core_reset)
      else $error("run permission disagrees with core reset");

   // Final stage always has the core free
   a_run_stage_free: assert property ((st_reg.stage == ST_RUN) |->
      !resets.core_reset)
      else $error("run stage with core held");

   // Combined reset keeps the sequencer in its hold stage
   a_stage_hold_comb: assert property (resets.combined_reset |->
      st_reg.stage == ST_HOLD)
      else $error("stage advanced under combined reset");

   // Synchronous source mid-run puts stages back in reset
   a_restart_from_sync: assert property ((sync_req && !resets.clock_generator_reset) |=>
      resets.clock_generator_reset && resets.peripheral_reset)
      else $error("synchronous source did not restart sequence");

   // Power-on return re-arms test-access reset and stretcher
   a_restart_from_por: assert property ((por_s && !resets.core_reset) |=>
      resets.jtag_reset && resets.por_stretched)
      else $error("power-on return did not re-arm resets");

   // Main scenarios worth seeing
   c_full_boot: cover property ($fell(resets.core_reset));
   c_sw_reset: cover property (!resets.core_reset ##1 sources.sw_write ##2 resets.core_reset);
   c_mid_restart: cover property (!resets.clock_generator_reset && resets.peripheral_reset ##1 resets.combined_reset);
   c_wd_restart: cover property (sources.watchdog_timeout_reset && !resets.sync_logic_reset ##1 resets.combined_reset);
   c_por_walk: cover property ($fell(resets.por_stretched));

endmodule

/* File: hw/srs_pkg.sv */
// Shared types and constants of the staged reset sequencer.
// Assumes one clock, the oscillator clock, feeds the whole sequencer.
package srs_pkg;

   // Stage lengths, in oscillator clock cycles, and counter width
   localparam int POR_STRETCH_CYCLES  = 64;
   localparam int SYNC_RELEASE_CYCLES = 3;
   localparam int CLKGEN_CYCLES       = 32;
   localparam int PERIPH_CYCLES       = 32;
   localparam int CORE_CYCLES         = 32;
   localparam int CNT_WIDTH           = 7;

   // Synchroniser depth and reset value of its flops
   localparam int SYNC_DEPTH          = 2;
   localparam logic [1:0] SYNC_RESET  = 2'h3;

   // Reset requests, all active high
   typedef struct packed {
      logic por_active;              // Raw power-on reset, asynchronous
      logic ext_active;              // External reset pin, asynchronous
      logic sw_write;                // Write of the reset bit in system_control_register
      logic watchdog_timeout_reset;  // Synchronous watchdog time-out
      logic clock_loss_reset;        // Synchronous watchdog clock-loss
   } srs_sources_type;

   // Reset outputs, all active high except core_run
   typedef struct packed {
      logic jtag_reset;
      logic por_stretched;
      logic combined_reset;
      logic sync_logic_reset;
      logic clock_generator_reset;
      logic peripheral_reset;
      logic core_reset;
      logic core_run;
   } srs_resets_type;

   localparam srs_resets_type RESETS_AT_RESET = '{
      jtag_reset:            1'b1,
      por_stretched:         1'b1,
      combined_reset:        1'b1,
      sync_logic_reset:      1'b1,
      clock_generator_reset: 1'b1,
      peripheral_reset:      1'b1,
      core_reset:            1'b1,
      core_run:              1'b0
   };

   typedef enum logic [2:0] {
      ST_HOLD,
      ST_CLKGEN,
      ST_PERIPH,
      ST_CORE,
      ST_RUN
   } srs_stage_type;

endpackage

/* File: verification/srs_core_model.sv */
// Behavioural model of the core and peripherals fed by the reset sequencer.
// Assumes the resets arrive as registered levels that change on the rising clk edge.
`timescale 1ns/100ps
module srs_core_model
   import srs_pkg::*;
(
   input  wire logic               clk,
   input  srs_pkg::srs_resets_type resets,
   input  wire logic               sw_req,
   output logic                    sw_write,
   output logic                    order_err,
   output logic [15:0]             exec_count
);
   // Software reset request: one write gives a one-cycle strobe
   always @(posedge clk) begin
      sw_write <= sw_req;
   end

   // Core counts executed cycles only once freed; stage order is watched
   always @(posedge clk) begin
      if (resets.core_run === 1'b1 && resets.core_reset === 1'b0) begin
         exec_count <= exec_count + 16'h1;
      end
      // Peripherals must never be freed ahead of the clock generator
      if ((resets.core_run && (resets.peripheral_reset || resets.clock_generator_reset || resets.core_reset))
          || (!resets.peripheral_reset && resets.clock_generator_reset)) begin
         order_err <= 1'b1;
      end
   end

   // Quiet start before the first edge
   initial begin
      sw_write = 1'b0;
      order_err = 1'b0;
      exec_count = 16'h0;
   end
endmodule

/* File: verification/staged_reset_sequencer_bench.sv */
// Self-checking bench of the staged reset sequencer with a core model behind it.
// Assumes default stage lengths; release times are counted in clk samples after each stimulus.
`timescale 1ns/100ps
module staged_reset_sequencer_bench;
   import srs_pkg::*;
   typedef struct {
      logic [1:0] lv;   // Power-on and pin levels
      logic [1:0] pl;   // Time-out and clock-loss pulse
      int         p;    // Pulse cycle, -1 for none
      int         q;    // Software write cycle, -1 for none
      int         e[7]; // Release: por, comb, sync, clkgen, periph, core, jtag; 255 ignored
   } srs_row_type;
   logic            clk = 1'b0;
   logic            nrst = 1'b0;
   logic            por = 1'b1;
   logic            ext = 1'b1;
   logic            wd = 1'b0;
   logic            loss = 1'b0;
   logic            sw_req = 1'b0;
   logic            sw_write;
   logic            order_err;
   logic [15:0]     exec_count;
   srs_sources_type src;
   srs_resets_type  resets;
   int              n_errors = 0;
   int              total_checks = 0;
   // Ordinary cases: 201 means still held at the end of the window
   srs_row_type rows[5] = '{
      '{2'b01, 2'b00, -1, -1, '{66, 201, 201, 201, 201, 201, 255}},
      '{2'b00, 2'b00, -1, -1, '{1, 3, 6, 35, 67, 99, 1}},
      '{2'b00, 2'b10, 0, -1, '{1, 2, 5, 34, 66, 98, 1}},
      '{2'b00, 2'b01, 0, -1, '{1, 2, 5, 34, 66, 98, 1}},
      '{2'b00, 2'b00, -1, 0, '{1, 3, 6, 35, 67, 99, 1}}};
   // Write ignored while sync logic held, restart mid-run, full power-on walk
   srs_row_type hand[3] = '{
      '{2'b00, 2'b10, 0, 3, '{1, 2, 5, 34, 66, 98, 1}},
      '{2'b00, 2'b10, 0, 50, '{1, 53, 56, 85, 117, 149, 1}},
      '{2'b00, 2'b00, -1, -1, '{66, 67, 70, 99, 131, 163, 255}}};

   assign src = '{por_active: por, ext_active: ext, sw_write: sw_write, watchdog_timeout_reset: wd,
                  clock_loss_reset: loss};

   // Oscillator clock, 25 MHz
   always #20 clk = ~clk;

   srs_sequencer srs_sequencer_inst (.clk(clk), .nrst(nrst), .sources(src), .resets(resets));
   srs_core_model srs_core_model_inst (.clk(clk), .resets(resets), .sw_req(sw_req), .sw_write(sw_write),
                                       .order_err(order_err), .exec_count(exec_count));

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %0d, seen %0d", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Drives one stimulus at falling edges, records the last asserted sample of each output
   task automatic run_case(input string nm, input srs_row_type r);
      int         last[8];
      logic [7:0] v;
      foreach (last[i]) last[i] = 0;
      por = r.lv[1];
      ext = r.lv[0];
      for (int k = 0; k < 200; k++) begin
         {wd, loss} = (k == r.p) ? r.pl : 2'b00;
         sw_req = (k == r.q);
         @(negedge clk);
         v = {resets.por_stretched, resets.combined_reset, resets.sync_logic_reset, resets.clock_generator_reset,
              resets.peripheral_reset, resets.core_reset, resets.jtag_reset, ~resets.core_run};
         for (int i = 0; i < 8; i++) if (v[7 - i] !== 1'b0) last[i] = k + 1;
      end
      for (int i = 0; i < 7; i++) begin
         if (r.e[i] != 255) check($sformatf("%s release %0d", nm, i), 8'(last[i] + 1), 8'(r.e[i]));
      end
      check($sformatf("%s core run", nm), 8'(last[7] + 1), 8'(r.e[5]));
      $display("test %s done, mismatches so far %0d", nm, n_errors);
   endtask

   // Main sequence, bounded throughout by the fixed case windows
   initial begin
      repeat (4) @(negedge clk);
      check("reset state", resets, RESETS_AT_RESET);
      nrst = 1'b1;
      foreach (rows[i]) run_case($sformatf("row%0d", i), rows[i]);
      run_case("refused write", hand[0]);
      run_case("restart", hand[1]);
      nrst = 1'b0;
      @(negedge clk);
      check("second reset", resets, RESETS_AT_RESET);
      nrst = 1'b1;
      run_case("power-on walk", hand[2]);
      check("core ran", 8'(exec_count != 16'h0), 8'h1);
      check("stage order", {7'h0, order_err}, 8'h0);
      tally_and_finish();
   end
endmodule
